// File: hw/atm_pkg.sv
// Package of constants and types for the auxiliary test signal multiplexer
package atm_pkg;
    localparam int unsigned ADDR_W  = 12;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned DAC_W   = 6;
    localparam int unsigned ADC_W   = 4;
    localparam int unsigned TBUS_W  = 8;
    localparam int unsigned TBSEL_W = 3;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_REVISION = 10'h037;
    localparam logic [9:0] IDX_SRC_SEL  = 10'h038;
    localparam logic [9:0] IDX_DAC1     = 10'h039;
    localparam logic [9:0] IDX_DAC2     = 10'h03A;
    localparam logic [9:0] IDX_TEST_SEL = 10'h040;
    localparam int unsigned IDX_LSB     = 2;

    localparam logic [7:0]         SRC_SEL_RESET = 8'h00;
    localparam logic [DAC_W-1:0]   DAC_RESET     = 6'h00;
    localparam logic [TBSEL_W-1:0] TBSEL_RESET   = 3'h0;

    // Selector field positions
    localparam int unsigned SEL1_MSB = 7;
    localparam int unsigned SEL1_LSB = 4;
    localparam int unsigned SEL2_MSB = 3;
    localparam int unsigned SEL2_LSB = 0;

    // Selector codes
    localparam logic [3:0] SRC_TRISTATE = 4'h0;
    localparam logic [3:0] SRC_DAC      = 4'h1;
    localparam logic [3:0] SRC_FIRST_CORRELATOR_SIGNAL    = 4'h2;
    localparam logic [3:0] SRC_SECOND_CORRELATOR_SIGNAL    = 4'h3;
    localparam logic [3:0] SRC_MINLVL   = 4'h4;
    localparam logic [3:0] SRC_ADC_I    = 4'h5;
    localparam logic [3:0] SRC_ADC_Q    = 4'h6;
    localparam logic [3:0] SRC_ADC_IQ   = 4'h7;
    localparam logic [3:0] SRC_PROD     = 4'h8;
    localparam logic [3:0] SRC_SMCLK    = 4'h9;
    localparam logic [3:0] SRC_HIGH     = 4'hA;
    localparam logic [3:0] SRC_LOW      = 4'hB;
    localparam logic [3:0] SRC_TX_ACT   = 4'hC;
    localparam logic [3:0] SRC_RX_ACT   = 4'hD;
    localparam logic [3:0] SRC_SUBC     = 4'hE;
    localparam logic [3:0] SRC_TBUS     = 4'hF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } atm_wr_state_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } atm_rd_state_type;

    typedef enum logic [5:0] {
        REG_NONE     = 6'b000001,
        REG_REVISION = 6'b000010,
        REG_SRC_SEL  = 6'b000100,
        REG_DAC1     = 6'b001000,
        REG_DAC2     = 6'b010000,
        REG_TEST_SEL = 6'b100000
    } atm_reg_type;

    typedef struct packed {
        logic             oe;
        logic             level;
        logic [DAC_W-1:0] analog;
    } atm_pin_type;

    typedef struct packed {
        logic [DAC_W-1:0] first_correlator_signal;
        logic [DAC_W-1:0] second_correlator_signal;
        logic [DAC_W-1:0] minlvl;
        logic [ADC_W-1:0] adc_i;
        logic [ADC_W-1:0] adc_q;
        logic [DAC_W-1:0] prod;
    } atm_analog_in_type;

    typedef struct packed {
        logic              smclk;
        logic              tx_active;
        logic              rx_active;
        logic              subc;
        logic [TBUS_W-1:0] test_bus;
    } atm_digital_in_type;
endpackage

// File: hw/atm_aux_test_mux.sv
// Auxiliary test pin multiplexer with AXI4-Lite register slave
`timescale 1ns/1ps
module atm_aux_test_mux #(
    // Arbitrary neutral revision code
    parameter logic [7:0] REVISION_CODE = 8'h5A
) (
    input  wire logic                         clk_i,           // Clock
    input  wire logic                         arst_n_i,        // Reset, low
    input  wire logic [atm_pkg::ADDR_W-1:0]   s_axi_awaddr,    // Write addr
    input  wire logic                         s_axi_awvalid,   // Addr valid
    output logic                              s_axi_awready,   // Addr ready
    input  wire logic [atm_pkg::DATA_W-1:0]   s_axi_wdata,     // Write data
    input  wire logic [3:0]                   s_axi_wstrb,     // Byte strobes
    input  wire logic                         s_axi_wvalid,    // Data valid
    output logic                              s_axi_wready,    // Data ready
    output logic [1:0]                        s_axi_bresp,     // Write resp
    output logic                              s_axi_bvalid,    // Resp valid
    input  wire logic                         s_axi_bready,    // Resp ready
    input  wire logic [atm_pkg::ADDR_W-1:0]   s_axi_araddr,    // Read addr
    input  wire logic                         s_axi_arvalid,   // Addr valid
    output logic                              s_axi_arready,   // Addr ready
    output logic [atm_pkg::DATA_W-1:0]        s_axi_rdata,     // Read data
    output logic [1:0]                        s_axi_rresp,     // Read resp
    output logic                              s_axi_rvalid,    // Data valid
    input  wire logic                         s_axi_rready,    // Data ready
    input  wire atm_pkg::atm_analog_in_type   analog_i,        // Analog taps
    input  wire atm_pkg::atm_digital_in_type  digital_i,       // Digital taps
    output atm_pkg::atm_pin_type              first_analog_test_pin_o, // Pin 1
    output atm_pkg::atm_pin_type              second_analog_test_pin_o // Pin 2
);

    default clocking dflt_cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    typedef struct packed {
        logic [7:0]                  src_sel;
        logic [atm_pkg::DAC_W-1:0]   first_test_dac;
        logic [atm_pkg::DAC_W-1:0]   second_test_dac;
        logic [atm_pkg::TBSEL_W-1:0] test_bus_bit_select;
        atm_pkg::atm_wr_state_type   wr_state;
        atm_pkg::atm_rd_state_type   rd_state;
        logic                        aw_got;
        logic                        w_got;
        logic [atm_pkg::ADDR_W-1:0]  awaddr;
        logic [atm_pkg::DATA_W-1:0]  wdata;
        logic                        wstrb0;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [atm_pkg::DATA_W-1:0]  rdata;
        logic [1:0]                  rresp;
        atm_pkg::atm_pin_type        pin1;
        atm_pkg::atm_pin_type        pin2;
        logic                        released;
    } atm_state_type;

    localparam atm_state_type ST_RESET = '{
        src_sel:             atm_pkg::SRC_SEL_RESET,
        first_test_dac:      atm_pkg::DAC_RESET,
        second_test_dac:     atm_pkg::DAC_RESET,
        test_bus_bit_select: atm_pkg::TBSEL_RESET,
        wr_state:            atm_pkg::WR_IDLE,
        rd_state:            atm_pkg::RD_IDLE,
        aw_got:              1'b0,
        w_got:               1'b0,
        awaddr:              '0,
        wdata:               '0,
        wstrb0:              1'b0,
        awready:             1'b1,
        wready:              1'b1,
        bvalid:              1'b0,
        bresp:               atm_pkg::RESP_OKAY,
        arready:             1'b1,
        rvalid:              1'b0,
        rdata:               '0,
        rresp:               atm_pkg::RESP_OKAY,
        pin1:                '0,
        pin2:                '0,
        released:            1'b0
    };

    atm_state_type st_r;
    atm_state_type st_nxt;

    // Maps a byte address onto a register
    function automatic atm_pkg::atm_reg_type decode_addr(
        input logic [atm_pkg::ADDR_W-1:0] addr
    );
        logic [9:0] idx;
        idx = addr[atm_pkg::ADDR_W-1:atm_pkg::IDX_LSB];
        unique case (idx)
            atm_pkg::IDX_REVISION: decode_addr = atm_pkg::REG_REVISION;
            atm_pkg::IDX_SRC_SEL:  decode_addr = atm_pkg::REG_SRC_SEL;
            atm_pkg::IDX_DAC1:     decode_addr = atm_pkg::REG_DAC1;
            atm_pkg::IDX_DAC2:     decode_addr = atm_pkg::REG_DAC2;
            atm_pkg::IDX_TEST_SEL: decode_addr = atm_pkg::REG_TEST_SEL;
            default:               decode_addr = atm_pkg::REG_NONE;
        endcase
    endfunction

    // Works out one pin's drive from its selector code
    function automatic atm_pkg::atm_pin_type pin_drive(
        input logic [3:0]                  code,
        input logic [atm_pkg::DAC_W-1:0]   dac,
        input atm_pkg::atm_analog_in_type  ana,
        input atm_pkg::atm_digital_in_type dig,
        input logic [atm_pkg::TBSEL_W-1:0] bitsel
    );
        atm_pkg::atm_pin_type p;
        logic [atm_pkg::ADC_W:0] iq_sum;
        iq_sum = {1'b0, ana.adc_i} + {1'b0, ana.adc_q};
        p = '0;
        p.oe = 1'b1;
        unique case (code)
            atm_pkg::SRC_TRISTATE: p.oe = 1'b0;
            atm_pkg::SRC_DAC:      p.analog = dac;
            atm_pkg::SRC_FIRST_CORRELATOR_SIGNAL:    p.analog = ana.first_correlator_signal;
            atm_pkg::SRC_SECOND_CORRELATOR_SIGNAL:    p.analog = ana.second_correlator_signal;
            atm_pkg::SRC_MINLVL:   p.analog = ana.minlvl;
            atm_pkg::SRC_ADC_I:    p.analog = {2'h0, ana.adc_i};
            atm_pkg::SRC_ADC_Q:    p.analog = {2'h0, ana.adc_q};
            atm_pkg::SRC_ADC_IQ:   p.analog = {1'h0, iq_sum};
            atm_pkg::SRC_PROD:     p.analog = ana.prod;
            atm_pkg::SRC_SMCLK:    p.level = dig.smclk;
            atm_pkg::SRC_HIGH:     p.level = 1'b1;
            atm_pkg::SRC_LOW:      p.level = 1'b0;
            atm_pkg::SRC_TX_ACT:   p.level = dig.tx_active;
            atm_pkg::SRC_RX_ACT:   p.level = dig.rx_active;
            atm_pkg::SRC_SUBC:     p.level = dig.subc;
            atm_pkg::SRC_TBUS:     p.level = dig.test_bus[bitsel];
        endcase
        pin_drive = p;
    endfunction

    always_comb begin
        atm_pkg::atm_reg_type wsel;
        atm_pkg::atm_reg_type rsel;
        st_nxt = st_r;
        st_nxt.released = 1'b1;
        wsel = atm_pkg::REG_NONE;
        rsel = decode_addr(s_axi_araddr);

        // Address and data are taken independently, in either order
        if (st_r.awready && s_axi_awvalid) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (st_r.wready && s_axi_wvalid) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.wdata  = s_axi_wdata;
            st_nxt.wstrb0 = s_axi_wstrb[0];
        end

        unique case (st_r.wr_state)
            atm_pkg::WR_IDLE: begin
                if (st_nxt.aw_got && st_nxt.w_got) begin
                    wsel = decode_addr(st_nxt.awaddr);
                    st_nxt.bresp = atm_pkg::RESP_OKAY;
                    if (st_nxt.wstrb0) begin
                        unique case (wsel)
                            atm_pkg::REG_SRC_SEL:
                                st_nxt.src_sel = st_nxt.wdata[7:0];
                            atm_pkg::REG_DAC1:
                                st_nxt.first_test_dac =
                                    st_nxt.wdata[atm_pkg::DAC_W-1:0];
                            atm_pkg::REG_DAC2:
                                st_nxt.second_test_dac =
                                    st_nxt.wdata[atm_pkg::DAC_W-1:0];
                            atm_pkg::REG_TEST_SEL:
                                st_nxt.test_bus_bit_select =
                                    st_nxt.wdata[atm_pkg::TBSEL_W-1:0];
                            // Revision has no storage to change
                            atm_pkg::REG_REVISION: ;
                            atm_pkg::REG_NONE: ;
                        endcase
                    end
                    if (wsel == atm_pkg::REG_NONE) begin
                        st_nxt.bresp = atm_pkg::RESP_SLVERR;
                    end
                    st_nxt.aw_got   = 1'b0;
                    st_nxt.w_got    = 1'b0;
                    st_nxt.bvalid   = 1'b1;
                    st_nxt.wr_state = atm_pkg::WR_RESP;
                end
            end
            atm_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.bvalid   = 1'b0;
                    st_nxt.wr_state = atm_pkg::WR_IDLE;
                end
            end
        endcase
        st_nxt.awready = (st_nxt.wr_state == atm_pkg::WR_IDLE) &&
                         !st_nxt.aw_got;
        st_nxt.wready  = (st_nxt.wr_state == atm_pkg::WR_IDLE) &&
                         !st_nxt.w_got;

        unique case (st_r.rd_state)
            atm_pkg::RD_IDLE: begin
                if (st_r.arready && s_axi_arvalid) begin
                    st_nxt.rdata = '0;
                    st_nxt.rresp = atm_pkg::RESP_OKAY;
                    unique case (rsel)
                        atm_pkg::REG_REVISION:
                            st_nxt.rdata[7:0] = REVISION_CODE;
                        atm_pkg::REG_SRC_SEL:
                            st_nxt.rdata[7:0] = st_r.src_sel;
                        atm_pkg::REG_DAC1:
                            st_nxt.rdata[atm_pkg::DAC_W-1:0] =
                                st_r.first_test_dac;
                        atm_pkg::REG_DAC2:
                            st_nxt.rdata[atm_pkg::DAC_W-1:0] =
                                st_r.second_test_dac;
                        atm_pkg::REG_TEST_SEL:
                            st_nxt.rdata[atm_pkg::TBSEL_W-1:0] =
                                st_r.test_bus_bit_select;
                        atm_pkg::REG_NONE:
                            st_nxt.rresp = atm_pkg::RESP_SLVERR;
                    endcase
                    st_nxt.rvalid   = 1'b1;
                    st_nxt.rd_state = atm_pkg::RD_DATA;
                end
            end
            atm_pkg::RD_DATA: begin
                if (s_axi_rready) begin
                    st_nxt.rvalid   = 1'b0;
                    st_nxt.rd_state = atm_pkg::RD_IDLE;
                end
            end
        endcase
        st_nxt.arready = (st_nxt.rd_state == atm_pkg::RD_IDLE);

        st_nxt.pin1 = pin_drive(
            st_r.src_sel[atm_pkg::SEL1_MSB:atm_pkg::SEL1_LSB],
            st_r.first_test_dac, analog_i, digital_i,
            st_r.test_bus_bit_select);
        st_nxt.pin2 = pin_drive(
            st_r.src_sel[atm_pkg::SEL2_MSB:atm_pkg::SEL2_LSB],
            st_r.second_test_dac, analog_i, digital_i,
            st_r.test_bus_bit_select);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready            = st_r.awready;
    assign s_axi_wready             = st_r.wready;
    assign s_axi_bvalid             = st_r.bvalid;
    assign s_axi_bresp              = st_r.bresp;
    assign s_axi_arready            = st_r.arready;
    assign s_axi_rvalid             = st_r.rvalid;
    assign s_axi_rdata              = st_r.rdata;
    assign s_axi_rresp              = st_r.rresp;
    assign first_analog_test_pin_o  = st_r.pin1;
    assign second_analog_test_pin_o = st_r.pin2;

    logic [3:0] sel1;
    logic [3:0] sel2;
    assign sel1 = st_r.src_sel[atm_pkg::SEL1_MSB:atm_pkg::SEL1_LSB];
    assign sel2 = st_r.src_sel[atm_pkg::SEL2_MSB:atm_pkg::SEL2_LSB];

    sequence ar_take(logic [9:0] idx);
        s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr[atm_pkg::ADDR_W-1:atm_pkg::IDX_LSB] == idx);
    endsequence

    sequence aw_take(logic [9:0] idx);
        (st_nxt.wr_state == atm_pkg::WR_RESP) &&
        (st_r.wr_state == atm_pkg::WR_IDLE) &&
        (st_nxt.awaddr[atm_pkg::ADDR_W-1:atm_pkg::IDX_LSB] == idx);
    endsequence

    rev_read_a: assert property (
        ar_take(atm_pkg::IDX_REVISION) |=> s_axi_rvalid &&
        (s_axi_rdata == {24'h000000, REVISION_CODE}))
        else $error("revision read wrong");
    pin_float_a: assert property (
        (sel1 == atm_pkg::SRC_TRISTATE) |=> !first_analog_test_pin_o.oe)
        else $error("first pin not floating");
    pin_high_low_a: assert property (
        (sel2 == atm_pkg::SRC_HIGH || sel2 == atm_pkg::SRC_LOW) |=>
        second_analog_test_pin_o.oe &&
        (second_analog_test_pin_o.level == ($past(sel2) == atm_pkg::SRC_HIGH)))
        else $error("second pin fixed level wrong");
    reset_float_a: assert property (
        !st_r.released |-> (st_r.src_sel == atm_pkg::SRC_SEL_RESET) &&
        !first_analog_test_pin_o.oe && !second_analog_test_pin_o.oe)
        else $error("pins not floating after reset");
    dac_route_a: assert property (
        (sel1 == atm_pkg::SRC_DAC) |=> first_analog_test_pin_o.oe &&
        (first_analog_test_pin_o.analog == $past(st_r.first_test_dac)))
        else $error("first DAC not routed");
    corr_route_a: assert property (
        (sel1 == atm_pkg::SRC_SECOND_CORRELATOR_SIGNAL) |=>
        (first_analog_test_pin_o.analog == $past(analog_i.second_correlator_signal)))
        else $error("correlator not routed");
    prod_route_a: assert property (
        (sel2 == atm_pkg::SRC_PROD) |=>
        (second_analog_test_pin_o.analog == $past(analog_i.prod)))
        else $error("production signal not routed");
    smclk_route_a: assert property (
        (sel1 == atm_pkg::SRC_SMCLK) |=>
        (first_analog_test_pin_o.level == $past(digital_i.smclk)))
        else $error("module clock not routed");
    tx_route_a: assert property (
        (sel2 == atm_pkg::SRC_TX_ACT) |=>
        (second_analog_test_pin_o.level == $past(digital_i.tx_active)))
        else $error("transmit active not routed");
    rx_route_a: assert property (
        (sel1 == atm_pkg::SRC_RX_ACT) |=>
        (first_analog_test_pin_o.level == $past(digital_i.rx_active)))
        else $error("receive active not routed");
    subc_route_a: assert property (
        (sel2 == atm_pkg::SRC_SUBC) |=>
        (second_analog_test_pin_o.level == $past(digital_i.subc)))
        else $error("subcarrier not routed");
    tbus_route_a: assert property (
        (sel1 == atm_pkg::SRC_TBUS) |=> (first_analog_test_pin_o.level ==
        $past(digital_i.test_bus[st_r.test_bus_bit_select])))
        else $error("test bus bit not routed");
    dac1_write_a: assert property (
        aw_take(atm_pkg::IDX_DAC1) ##0 st_nxt.wstrb0 |=>
        (st_r.first_test_dac == $past(st_nxt.wdata[atm_pkg::DAC_W-1:0])))
        else $error("first DAC write lost");
    dac1_rsvd_a: assert property (
        ar_take(atm_pkg::IDX_DAC1) |=> (s_axi_rdata[31:6] == 26'h0000000))
        else $error("first DAC reserved bits set");
    dac2_rsvd_a: assert property (
        ar_take(atm_pkg::IDX_DAC2) |=> (s_axi_rdata[31:6] == 26'h0000000) &&
        (s_axi_rdata[5:0] == $past(st_r.second_test_dac)))
        else $error("second DAC readback wrong");
    dac2_route_a: assert property (
        (sel2 == atm_pkg::SRC_DAC) |=>
        (second_analog_test_pin_o.analog == $past(st_r.second_test_dac)))
        else $error("second DAC not routed");
    rev_write_a: assert property (
        aw_take(atm_pkg::IDX_REVISION) |=> $stable(st_r.src_sel) &&
        $stable(st_r.first_test_dac) && $stable(st_r.second_test_dac))
        else $error("revision write changed state");

endmodule // atm_aux_test_mux

// File: sim/atm_aux_test_mux_tb.sv
// Self-checking bench for the auxiliary test pin multiplexer
`timescale 1ns/1ps
module atm_aux_test_mux_tb;
    localparam logic [7:0] REV = 8'hC3; // Arbitrary revision code
    logic                        clk_i    = 1'h0;
    logic                        arst_n_i = 1'h0;
    logic [11:0]                 awaddr   = 12'h000;
    logic [11:0]                 araddr   = 12'h000;
    logic [31:0]                 wdata    = 32'h0;
    logic                        awv      = 1'h0;
    logic                        wv       = 1'h0;
    logic                        bready   = 1'h0;
    logic                        arv      = 1'h0;
    logic                        rready   = 1'h0;
    logic                        awready, wready, bvalid, arready, rvalid;
    logic [1:0]                  bresp, rresp;
    logic [31:0]                 rdata;
    atm_pkg::atm_analog_in_type  ana = '0;
    atm_pkg::atm_digital_in_type dig = '0;
    atm_pkg::atm_pin_type        p1, p2;
    logic [33:0]                 exp_q[$];
    int                          err_count = 0, check_count = 0, cyc = 0;
    int                          seed = 32'hF255CCEF;
    logic [5:0]                  d1, d2;
    logic [2:0]                  bs;
    atm_aux_test_mux #(.REVISION_CODE(REV)) atm_aux_test_mux_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .analog_i(ana), .digital_i(dig),
        .first_analog_test_pin_o(p1), .second_analog_test_pin_o(p2));
    initial forever #5 clk_i = ~clk_i;
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'h1;
        wv     <= 1'h1;
        bready <= 1'h1;
        fork
            begin do @(posedge clk_i); while (!awready); awv <= 1'h0; end
            begin do @(posedge clk_i); while (!wready); wv <= 1'h0; end
        join
        do @(posedge clk_i); while (!bvalid);
        bready <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        exp_q.push_back({r, d});
        araddr <= a;
        arv    <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk_i); while (!arready);
        arv <= 1'h0;
        do @(posedge clk_i); while (!rvalid);
        rready <= 1'h0;
        @(posedge clk_i);
    endtask
    function automatic logic [33:0] pin_exp(input logic [3:0] c,
                                            input logic [5:0] d);
        logic [5:0] a;
        logic       l;
        a = 6'h00;
        l = 1'h0;
        case (c)
            4'h1: a = d;
            4'h2: a = ana.first_correlator_signal;
            4'h3: a = ana.second_correlator_signal;
            4'h4: a = ana.minlvl;
            4'h5: a = {2'h0, ana.adc_i};
            4'h6: a = {2'h0, ana.adc_q};
            4'h7: a = {2'h0, ana.adc_i} + {2'h0, ana.adc_q};
            4'h8: a = ana.prod;
            4'h9: l = dig.smclk;
            4'hA: l = 1'h1;
            4'hC: l = dig.tx_active;
            4'hD: l = dig.rx_active;
            4'hE: l = dig.subc;
            4'hF: l = dig.test_bus[bs];
            default: l = 1'h0;
        endcase
        return {26'h0, c != 4'h0, l, a};
    endfunction
    // Read data and write responses are matched against the oldest note
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
        if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        d1 = 6'($random(seed));
        d2 = 6'($random(seed));
        bs = 3'($random(seed));
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'h1;
        rd(12'h0E0, 32'h0, 2'h0);
        chk({26'h0, p2}, 34'h0);
        chk({26'h0, p1}, 34'h0);
        wr(12'h0DC, 32'hFF, 2'h0);
        rd(12'h0DC, {24'h0, REV}, 2'h0);
        wr(12'h0E4, {24'h0, 2'h3, d1}, 2'h0);
        rd(12'h0E4, {26'h0, d1}, 2'h0);
        wr(12'h0E8, {24'h0, 2'h3, d2}, 2'h0);
        rd(12'h0E8, {26'h0, d2}, 2'h0);
        wr(12'h100, {29'h0, bs}, 2'h0);
        wr(12'h0F0, 32'h0, 2'h2);
        rd(12'h0F0, 32'h0, 2'h2);
        $display("Test registers done");
        for (int i = 0; i < 16; i++) begin
            ana <= 32'($random(seed));
            dig <= 12'($random(seed));
            wr(12'h0E0, {24'h0, 4'(i), ~4'(i)}, 2'h0);
            repeat (2) @(posedge clk_i);
            #1;
            chk({26'h0, p1}, pin_exp(4'(i), d1));
            chk({26'h0, p2}, pin_exp(~4'(i), d2));
            @(posedge clk_i);
        end
        rd(12'h0E0, 32'h000000F0, 2'h0);
        $display("Test pin sources done");
        end_sim();
    end
endmodule // atm_aux_test_mux_tb
